// ===== mcs_port.sv
// mcs_port: serial management slave, 64-bit frames, sampled on mgmt clock
// assumes: pull-up on the shared data line; register file sits outside
// Behaviour
// - management clock is asynchronous; only sampled through synchronisers
// - every frame needs its own full preamble; frames are 64 bits
// - start 00, opcode 00 address, 01 write, 11 read, 10 read-inc
// - port address sampled from straps after reset; match required
// - port and group address fields arrive msb first
// - address frame: turnaround 10, then 16-bit register address msb first
// - write frame: turnaround 10, then 16 data bits stored to address
// - read: release first turnaround bit, drive 0, then 16 bits msb first
// - driver enabled only while answering a read whose port address matches ours
// - line released during idle and first turnaround bit; pull-up gives high
// - read answers zeros on group mismatch with port match, ones on port mismatch
// - port operates only while out of hardware reset, bar a read fetch in the first cycle port_live is low
`timescale 1ns/100ps
module mcs_port
  import mcs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_hardware_reset_pin_n,
  input  wire logic [4:0]  i_port_strap,
  input  wire logic        i_mdc,
  input  wire logic        i_mdio,
  input  wire logic [15:0] i_reg_rdata,
  output logic             o_mdio,
  output logic             o_mdio_oe,
  output logic [15:0]      o_reg_addr,
  output logic [15:0]      o_reg_wdata,
  output logic             o_reg_wr,
  output logic             o_reg_rd
);
  logic       mdc_rise;
  logic       mdc_fall;
  logic       bit_in;
  logic [1:0] rstn_sync;
  logic       strap_load;
  logic [4:0] strap_s1;
  logic [4:0] strap_s2;
  logic [4:0] port_id;
  mcs_state_t state;
  logic [5:0] pre_cnt;
  logic [5:0] bit_cnt;
  logic [15:0] shift_in;
  logic [1:0] opcode;
  logic       port_hit;
  logic       grp_hit;
  logic [15:0] reg_addr;
  logic [15:0] shift_out;
  logic       drive;
  logic       out_bit;
  logic       wr_pulse;
  logic       rd_pulse;

  // edges of the foreign management clock, two flops deep
  mcs_sampler u_sampler (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_mdc   (i_mdc),
    .i_mdio  (i_mdio),
    .o_rise  (mdc_rise),
    .o_fall  (mdc_fall),
    .o_data  (bit_in)
  );

  // hardware reset pin synchronised; port held idle while low, bar a read fetch in the first cycle port_live is low
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) rstn_sync <= 2'h0;
    else         rstn_sync <= {rstn_sync[0], i_hardware_reset_pin_n};
  end
  wire port_live = rstn_sync[1];

  // strap pins pass two flops; no reset, so they track the pins in reset
  always_ff @(posedge i_mclk) begin
    strap_s1 <= i_port_strap;
    strap_s2 <= strap_s1;
  end

  // strap capture one cycle after any reset release
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) strap_load <= 1'b1;
    else         strap_load <= ~port_live;
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset)         port_id <= 5'h00;
    else if (strap_load) port_id <= strap_s2;
  end

  // frame field decode
  wire       is_read   = opcode[1];
  wire [5:0] next_cnt  = bit_cnt + 6'h01;
  wire       pre_done  = (pre_cnt == 6'(MCS_PREAMBLE_LEN));
  wire       start_ok  = ~bit_in & pre_done;
  wire       last_bit  = (bit_cnt == MCS_CNT_LAST);
  wire [15:0] next_sin = {shift_in[14:0], bit_in};
  // read word: register data on full hit, zeros on group-only miss, ones on port miss
  wire [15:0] rd_word  = (port_hit & grp_hit) ? i_reg_rdata :
                         port_hit ? MCS_DATA_ZERO :
                         MCS_DATA_ONES;
  wire       port_eq   = (next_sin[4:0] == port_id);
  wire       grp_eq    = (next_sin[4:0] == MCS_GROUP_ID);

  // frame receiver: counts bits after start, sampled on rising mgmt edge
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state    <= MCS_ST_HUNT;
      pre_cnt  <= MCS_PRE_CNT_RST;
      bit_cnt  <= 6'h00;
      shift_in <= 16'h0000;
      opcode   <= MCS_OP_ADDR;
      port_hit <= 1'b0;
      grp_hit  <= 1'b0;
    end else if (!port_live) begin
      state    <= MCS_ST_HUNT;
      pre_cnt  <= MCS_PRE_CNT_RST;
      bit_cnt  <= 6'h00;
    end else if (mdc_rise) begin
      unique case (state)
        MCS_ST_HUNT: begin
          // ones count up, saturate; a zero after 32 is start bit 0
          if (bit_in) begin
            if (!pre_done) pre_cnt <= pre_cnt + 6'h01;
          end else begin
            pre_cnt <= MCS_PRE_CNT_RST;
            if (start_ok) begin
              // first start bit taken here; count 1 is the second one
              state   <= MCS_ST_FRAME;
              bit_cnt <= 6'h01;
            end
          end
        end
        MCS_ST_FRAME: begin
          bit_cnt  <= next_cnt;
          shift_in <= next_sin;
          if (bit_cnt == 6'h01 && bit_in != MCS_START_CODE[0])
            state <= MCS_ST_HUNT;                  // bad start field
          if (bit_cnt == MCS_CNT_OPCODE)
            opcode <= next_sin[1:0];
          if (bit_cnt == MCS_CNT_PORT_END)
            port_hit <= port_eq;
          if (bit_cnt == MCS_CNT_GRP_END)
            grp_hit <= grp_eq;
          if (last_bit)
            state <= MCS_ST_HUNT;
        end
        default: state <= MCS_ST_HUNT;
      endcase
    end
  end

  // write and address completion strobes, read fetch strobe
  wire frame_end = mdc_rise & (state == MCS_ST_FRAME) & last_bit & port_live;
  wire hit_both  = port_hit & grp_hit;
  wire addr_done = frame_end & hit_both & (opcode == MCS_OP_ADDR);
  wire wr_done   = frame_end & hit_both & (opcode == MCS_OP_WRITE);
  wire inc_done  = frame_end & hit_both & (opcode == MCS_OP_READ_INC);
  wire fetch     = mdc_rise & (state == MCS_ST_FRAME) & is_read &
                   (bit_cnt == MCS_CNT_GRP_END + 6'h01);

  // held register address
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset)        reg_addr <= MCS_RST_ADDR;
    else if (addr_done) reg_addr <= next_sin;
    else if (inc_done)  reg_addr <= reg_addr + 16'h0001;
  end

  // write strobe with captured data word
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wr_pulse    <= 1'b0;
      rd_pulse    <= 1'b0;
      o_reg_wdata <= 16'h0000;
    end else begin
      wr_pulse <= wr_done;
      rd_pulse <= fetch & hit_both;
      if (wr_done) o_reg_wdata <= next_sin;
    end
  end

  // read driver: changes on falling mgmt edge, released otherwise
  // only a port match may take the shared line; a port miss leaves the
  // all-ones answer to the pull-up, so out_bit never goes low undriven
  wire ta2_edge = mdc_fall & (state == MCS_ST_FRAME) & is_read & port_live &
                  port_hit & (bit_cnt == MCS_CNT_TA2);
  wire drv_end  = mdc_fall & (state != MCS_ST_FRAME);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      drive     <= 1'b0;
      out_bit   <= 1'b1;
      shift_out <= MCS_DATA_ONES;
    end else if (!port_live || drv_end) begin
      drive   <= 1'b0;
      out_bit <= 1'b1;
    end else if (ta2_edge) begin
      drive     <= 1'b1;
      out_bit   <= 1'b0;
      shift_out <= rd_word;
    end else if (mdc_fall && drive) begin
      out_bit   <= shift_out[15];
      shift_out <= {shift_out[14:0], 1'b1};
    end
  end

  // outputs straight from flops
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_mdio     <= 1'b1;
      o_mdio_oe  <= 1'b0;
      o_reg_addr <= MCS_RST_ADDR;
      o_reg_wr   <= 1'b0;
      o_reg_rd   <= 1'b0;
    end else begin
      o_mdio     <= out_bit;
      o_mdio_oe  <= drive;
      o_reg_addr <= reg_addr;
      o_reg_wr   <= wr_pulse;
      o_reg_rd   <= rd_pulse;
    end
  end
endmodule : mcs_port

// ===== mcs_pkg.sv
// mcs_pkg: constants for the serial management slave port
// assumes: shared by the port top and its bit sampler
package mcs_pkg;
  localparam int        MCS_PREAMBLE_LEN  = 32;
  localparam logic [1:0] MCS_OP_ADDR      = 2'h0;
  localparam logic [1:0] MCS_OP_WRITE     = 2'h1;
  localparam logic [1:0] MCS_OP_READ      = 2'h3;
  localparam logic [1:0] MCS_OP_READ_INC  = 2'h2;
  localparam logic [1:0] MCS_START_CODE   = 2'h0;
  localparam logic [5:0] MCS_CNT_OPCODE   = 6'h03;
  localparam logic [5:0] MCS_CNT_PORT_END = 6'h08;
  localparam logic [5:0] MCS_CNT_GRP_END  = 6'h0d;
  localparam logic [5:0] MCS_CNT_TA2      = 6'h0f;
  localparam logic [5:0] MCS_CNT_LAST     = 6'h1f;
  localparam logic [15:0] MCS_RST_ADDR    = 16'h0000;
  localparam logic [15:0] MCS_DATA_ZERO   = 16'h0000;
  localparam logic [15:0] MCS_DATA_ONES   = 16'hffff;
  localparam logic [4:0] MCS_GROUP_ID     = 5'h01; // arbitrary value
  localparam logic [5:0] MCS_PRE_CNT_RST  = 6'h00;
  typedef enum logic [1:0] {
    MCS_ST_HUNT,
    MCS_ST_FRAME
  } mcs_state_t;
endpackage : mcs_pkg

// ===== mcs_sampler.sv
// mcs_sampler: two-stage synchroniser for clock and data, edge detection
// assumes: management clock is slow (<=12.5 MHz) against i_mclk
`timescale 1ns/100ps
module mcs_sampler
  import mcs_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_mdc,
  input  wire logic i_mdio,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_data
);
  logic [2:0] clk_sync;
  logic [1:0] dat_sync;

  // clock and data synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      clk_sync <= 3'h0;
      dat_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[1:0], i_mdc};
      dat_sync <= {dat_sync[0], i_mdio};
    end
  end

  // edges from stages 1 and 2 only
  assign o_rise = clk_sync[1] & ~clk_sync[2];
  assign o_fall = ~clk_sync[1] & clk_sync[2];
  assign o_data = dat_sync[1];
endmodule : mcs_sampler

// ===== mcs_port_sva.sv
// mcs_port_sva: port-level assertions for the management slave
// assumes: bound to mcs_port, sees its ports only
`timescale 1ns/100ps
module mcs_port_sva (
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic        i_hardware_reset_pin_n,
  input wire logic        o_mdio,
  input wire logic        o_mdio_oe,
  input wire logic [15:0] o_reg_addr,
  input wire logic        o_reg_wr,
  input wire logic        o_reg_rd
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // line ownership and read answer framing
  a_answer_opens_zero: assert property
    ($rose(o_mdio_oe) |-> !o_mdio)
    else $error("read answer does not open with zero");
  a_answer_holds_on: assert property
    ($rose(o_mdio_oe) |-> o_mdio_oe[*8])
    else $error("driver dropped inside one bit time");
  a_idle_line_high: assert property
    (!o_mdio_oe |-> o_mdio)
    else $error("data out low while released");
  // pin passes two sync flops and two more stages before the outputs
  a_pin_low_quiet: assert property
    (!i_hardware_reset_pin_n[*5] |-> !o_mdio_oe && !o_reg_wr)
    else $error("port active while reset pin low");
  // strobes and address holding
  a_write_one_cycle: assert property
    (o_reg_wr |=> !o_reg_wr)
    else $error("write strobe longer than one cycle");
  a_read_one_cycle: assert property
    (o_reg_rd |=> !o_reg_rd)
    else $error("read strobe longer than one cycle");
  a_write_not_driving: assert property
    (o_reg_wr |-> !o_mdio_oe)
    else $error("driver on during a write");
  a_addr_steady_strobe: assert property
    ($changed(o_reg_addr) |-> !o_reg_wr && !o_reg_rd)
    else $error("register address moved under a strobe");
  c_write: cover property (o_reg_wr);
  c_read: cover property (o_reg_rd);
  c_answer: cover property ($rose(o_mdio_oe));
  c_addr_move: cover property ($changed(o_reg_addr));
endmodule : mcs_port_sva

// ===== mcs_station.sv
// mcs_station: station controller model, drives clock and data
// assumes: the bench resolves the shared line with a pull-up
`timescale 1ns/100ps
module mcs_station (
  input  wire logic i_mdio,
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe
);
  // clock stands low and line released between frames
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // one frame; 80 ns clock, sample at end of high phase
  task automatic frame(input int pre, input logic [1:0] op,
      input logic [4:0] pa, input logic [4:0] ga, input logic [15:0] d,
      output logic [15:0] rd);
    logic [31:0] word;
    word = {2'b00, op, pa, ga, 2'b10, d};
    rd = 16'h0000;
    // link signals change by non-blocking assignment, so a clock edge
    // that falls in the same step sees the old value, never a race
    for (int i = 0; i < pre + 32; i++) begin
      o_mdc     <= 1'b0;
      o_mdio    <= (i < pre) ? 1'b1 :
                   word[31 - (i - pre)];
      o_mdio_oe <= !(op[1] && i >= pre + 14);
      #40 o_mdc <= 1'b1;
      #40 rd = {rd[14:0], i_mdio};
    end
    o_mdc     <= 1'b0;                          // stands low
    o_mdio_oe <= 1'b0;
    #400;
  endtask : frame
endmodule : mcs_station

// ===== tb.sv
// tb: self-checking bench for the serial management slave port
// assumes: station model on the link; pull-up on the shared line
`timescale 1ns/100ps
module tb;
  import mcs_pkg::*;
  localparam logic [4:0] PORT = 5'h05;
  logic        i_mclk, i_reset, hw_n, o_mdio, o_oe, reg_wr, reg_rd;
  logic        st_mdc, st_mdio, st_oe, line, oe_seen;
  logic [4:0]  strap;
  logic [15:0] rdata, reg_addr, reg_wdata, wr_data, rd;
  int          errors, tests_run, wr_cnt, rd_cnt;
  // shared line with pull-up; register file answers addr xor 5a5a
  assign line = o_oe ? o_mdio : (st_oe ? st_mdio : 1'b1);
  always @(posedge i_mclk) rdata <= reg_addr ^ 16'h5a5a;
  always @(posedge i_mclk) if (reg_wr) begin
    wr_cnt <= wr_cnt + 1;
    wr_data <= reg_wdata;
  end
  // read strobes and any port drive of the shared line
  always @(posedge i_mclk) begin
    if (reg_rd) rd_cnt <= rd_cnt + 1;
    if (o_oe) oe_seen <= 1'b1;
  end
  mcs_station sm (.i_mdio(line), .o_mdc(st_mdc), .o_mdio(st_mdio),
    .o_mdio_oe(st_oe));
  mcs_port uut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_hardware_reset_pin_n(hw_n), .i_port_strap(strap), .i_mdc(st_mdc),
    .i_mdio(line), .i_reg_rdata(rdata), .o_mdio(o_mdio), .o_mdio_oe(o_oe),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic t_write;
    sm.frame(32, MCS_OP_ADDR, PORT, MCS_GROUP_ID, 16'h1234, rd);
    chk("address", reg_addr, 16'h1234);
    sm.frame(32, MCS_OP_WRITE, PORT, MCS_GROUP_ID, 16'ha5c3, rd);
    chk("write count", 16'(wr_cnt), 16'h0001);
    chk("write data", wr_data, 16'ha5c3);
    chk("held address", reg_addr, 16'h1234);
    $display("t_write done");
  endtask : t_write
  // register file answers address xor 5a5a: 1234 gives 486e
  task automatic t_read;
    sm.frame(32, MCS_OP_READ, PORT, MCS_GROUP_ID, 16'h0000, rd);
    chk("read data", rd, 16'h486e);
    sm.frame(32, MCS_OP_READ_INC, PORT, MCS_GROUP_ID, 16'h0000, rd);
    chk("inc read data", rd, 16'h486e);
    chk("inc address", reg_addr, 16'h1235);
    sm.frame(32, MCS_OP_READ, PORT, MCS_GROUP_ID, 16'h0000, rd);
    chk("next read", rd, 16'h486f);
    chk("read strobes", 16'(rd_cnt), 16'h0003);
    $display("t_read done");
  endtask : t_read
  task automatic t_miss;
    oe_seen = 1'b0;
    sm.frame(32, MCS_OP_READ, PORT ^ 5'h01, MCS_GROUP_ID, 16'h0000, rd);
    chk("port miss read", rd, 16'hffff);
    chk("port miss driver", 16'(oe_seen), 16'h0000);
    sm.frame(32, MCS_OP_READ, PORT, MCS_GROUP_ID ^ 5'h01, 16'h0000, rd);
    chk("group miss read", rd, 16'h0000);
    chk("group miss driver", 16'(oe_seen), 16'h0001);
    chk("miss strobes", 16'(rd_cnt), 16'h0003);
    sm.frame(32, MCS_OP_WRITE, PORT ^ 5'h10, MCS_GROUP_ID, 16'h0f0f, rd);
    sm.frame(32, MCS_OP_ADDR, PORT, MCS_GROUP_ID, 16'h0000, rd);
    sm.frame(20, MCS_OP_WRITE, PORT, MCS_GROUP_ID, 16'h0ff0, rd);
    chk("ignored writes", 16'(wr_cnt), 16'h0001);
    chk("zero address", reg_addr, 16'h0000);
    $display("t_miss done");
  endtask : t_miss
  task automatic t_pin;
    @(posedge i_mclk) hw_n <= 1'b0;
    strap <= 5'h1a;
    sm.frame(32, MCS_OP_WRITE, 5'h1a, MCS_GROUP_ID, 16'h7777, rd);
    chk("write while pin low", 16'(wr_cnt), 16'h0001);
    @(posedge i_mclk) hw_n <= 1'b1;
    repeat (8) @(posedge i_mclk);
    sm.frame(32, MCS_OP_WRITE, 5'h1a, MCS_GROUP_ID, 16'h3c3c, rd);
    chk("new strap write", wr_data, 16'h3c3c);
    chk("new strap count", 16'(wr_cnt), 16'h0002);
    $display("t_pin done");
  endtask : t_pin
  // clock and watchdog
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {i_reset, hw_n, strap, errors, tests_run, wr_cnt} = {2'b11, PORT, 96'd0};
    rdata = 16'h0000;
    rd_cnt = 0;
    oe_seen = 1'b0;
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (6) @(posedge i_mclk);
    t_write();
    t_read();
    t_miss();
    t_pin();
    tally_and_finish();
  end
endmodule : tb
bind mcs_port mcs_port_sva u_sva (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_hardware_reset_pin_n(i_hardware_reset_pin_n), .o_mdio(o_mdio),
  .o_mdio_oe(o_mdio_oe), .o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr),
  .o_reg_rd(o_reg_rd));
